// File: rtl/prc_pkg.sv
// Shared constants and carrier types for the run-control and LED block
package prc_pkg;

	// ------------------------------------------------------------
	// AXI4-Lite register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] PRC_CTRL_ADDR = 8'h00;
	localparam logic [7:0] PRC_STAT_ADDR = 8'h04;
	localparam logic [7:0] PRC_ERR_ADDR = 8'h08;
	localparam logic [7:0] PRC_CFG_ADDR = 8'h0C;

	// CTRL write bits (self-clearing commands)
	localparam int PRC_CTRL_START = 0;
	localparam int PRC_CTRL_STOP = 1;
	localparam int PRC_CTRL_PROG_OK = 2;
	localparam int PRC_CTRL_COMM_ERR = 3;
	localparam int PRC_CTRL_COMM_OK = 4;
	localparam int PRC_CTRL_CLR_FAULT = 5;
	localparam int PRC_CTRL_START_KIND = 8;

	// AXI responses
	localparam logic [1:0] PRC_RESP_OKAY = 2'b00;
	localparam logic [1:0] PRC_RESP_SLVERR = 2'b10;

	// Selector codes and DIP positions
	localparam logic [1:0] PRC_SEL_RUN = 2'b01;
	localparam logic [1:0] PRC_SEL_STOP = 2'b00;
	localparam logic [1:0] PRC_SEL_MRES = 2'b10;
	localparam int PRC_DIP_MASTER = 3;
	localparam int PRC_DIP_CAN2 = 4;
	localparam int PRC_DIP_CFG = 7;
	localparam logic [2:0] PRC_RATE_DEFAULT = 3'h0;

	// Blink periods in clock cycles, and the short flash on/off ratio
	localparam int PRC_SLOW_CYC = 50_000_000;
	localparam int PRC_FAST_CYC = 12_500_000;
	localparam int PRC_SHORT_CYC = 45_000_000;
	localparam int PRC_SHORT_ON = 1;
	localparam int PRC_SHORT_OFF = 8;

	typedef enum logic [3:0]
	{
		PRC_ST_STOP = 4'b0001,
		PRC_ST_READY = 4'b0010,
		PRC_ST_RUN = 4'b0100,
		PRC_ST_MRES = 4'b1000
	} prc_state_t;

	typedef struct packed
	{
		logic [7:0] node_addr;
		logic [2:0] rate_sel;
		logic master_en;
		logic can2_en;
		logic cfg_mode;
	} prc_cfg_t;

	typedef struct packed
	{
		logic run_led;
		logic err_led;
	} prc_led_t;

	typedef struct packed
	{
		logic [1:0] sel_m;
		logic [1:0] sel_s;
		prc_state_t state;
		logic host_run;
		logic prog_ok;
		logic fault;
		logic comm_err;
		logic [7:0] err_code;
		logic [15:0] err_info;
		logic [2:0] start_kind;
		logic cfg_done;
		prc_cfg_t cfg;
		logic [31:0] blink_cnt;
		prc_led_t led;
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} prc_state_reg_t;

endpackage

// File: rtl/prc_run_ctrl.sv
// Run/stop control, LED pattern generator and AXI4-Lite register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps

// How it works
// - Program runs only with selector at run and a host start command
// - Run is a level AND of selector and host start, order free
// - Selector right is run, middle is stop, left is module reset
// - Green LED dark in stop: no program, host stop, or fault
// - Host run with selector at stop flashes green one on, eight off
// - Running program blinks green slowly, equal on and off
// - Module reset blinks green and red fast, equal on and off
// - Red LED dark with no error pending, outside module reset
// - Serious fault forces stop and lights red steadily, outside module reset
// - Fault code and description held for host readback
// - Link error blinks red slowly; program keeps running
// - Link error clears when the host writes the comm-ok bit to CTRL
// - Node address is high switch nibble over low switch nibble
// - Switches and DIP bank sampled once, before operation
// - DIP map: rate, master, second CAN, reserved, config mode
// - Master DIP off gives slave, on gives master on primary CAN
// - Second CAN disabled unless its DIP is on
// - Rate bits all off give the default serial rate
module prc_run_ctrl
	import prc_pkg::*;
#(
	parameter int SLOW_CYC = PRC_SLOW_CYC,
	parameter int FAST_CYC = PRC_FAST_CYC,
	parameter int SHORT_CYC = PRC_SHORT_CYC
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Front panel (asynchronous pins)
	input wire logic [1:0] run_selector,
	input wire logic [3:0] addr_switch_high,
	input wire logic [3:0] addr_switch_low,
	input wire logic [7:0] config_dip_bank,
	// Internal fault report from the program engine
	input wire logic fault_pulse,
	input wire logic [7:0] fault_code,
	input wire logic [15:0] fault_info,
	// Outputs
	output logic run_led,
	output logic err_led,
	output logic prog_exec,
	output logic mres_req,
	output prc_cfg_t cfg_out,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	prc_state_reg_t q, d;
	prc_state_t nxt;
	logic do_wr;
	logic [31:0] wv;
	logic sel_run;
	logic sel_mres;
	logic slow_ph;
	logic fast_ph;
	logic short_ph;

	// Blink phase from one free-running counter modulo the period
	function automatic logic half_phase(input logic [31:0] cnt, input int per);
		half_phase = (cnt % 32'(per)) < 32'(per / 2);
	endfunction

	assign s_axi_awready = !q.aw_ok && !q.bvalid;
	assign s_axi_wready = !q.w_ok && !q.bvalid;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign run_led = q.led.run_led;
	assign err_led = q.led.err_led;
	assign prog_exec = (q.state == PRC_ST_RUN);
	assign mres_req = (q.state == PRC_ST_MRES);
	assign cfg_out = q.cfg;

	always_comb
	begin
		d = q;
		wv = '0;
		// ------------------------------------------------------------
		// Pin synchronisers
		// ------------------------------------------------------------
		d.sel_m = run_selector;
		d.sel_s = q.sel_m;
		sel_run = (q.sel_s == PRC_SEL_RUN);
		sel_mres = (q.sel_s == PRC_SEL_MRES);

		// ------------------------------------------------------------
		// Configuration capture
		// ------------------------------------------------------------
		// Sampled once after reset so that moving a switch in operation
		// has no effect until the next reset.
		if (!q.cfg_done)
		begin
			d.cfg_done = 1'b1;
			d.cfg.node_addr = {addr_switch_high, addr_switch_low};
			d.cfg.rate_sel = config_dip_bank[2:0];
			d.cfg.master_en = config_dip_bank[PRC_DIP_MASTER];
			d.cfg.can2_en = config_dip_bank[PRC_DIP_CAN2];
			d.cfg.cfg_mode = config_dip_bank[PRC_DIP_CFG];
		end

		// ------------------------------------------------------------
		// AXI4-Lite write channel
		// ------------------------------------------------------------
		if (s_axi_awvalid && s_axi_awready)
		begin
			d.aw_ok = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			d.w_ok = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		do_wr = q.aw_ok && q.w_ok && !q.bvalid;
		if (do_wr)
		begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = (q.aw_addr == PRC_CTRL_ADDR) ? PRC_RESP_OKAY
				: PRC_RESP_SLVERR;
			if (q.aw_addr == PRC_CTRL_ADDR)
				wv = q.w_data & {{8{q.w_strb[3]}}, {8{q.w_strb[2]}},
					{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;

		// ------------------------------------------------------------
		// AXI4-Lite read channel
		// ------------------------------------------------------------
		// Reads have no side effects, so software may poll freely
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			d.rvalid = 1'b1;
			d.rresp = PRC_RESP_OKAY;
			d.rdata = '0;
			case (s_axi_araddr)
				PRC_CTRL_ADDR: d.rdata = {21'h0, q.start_kind, 8'h00};
				PRC_STAT_ADDR: d.rdata = {20'h0, q.sel_s, q.led.err_led,
					q.led.run_led, q.state, q.comm_err, q.fault,
					q.prog_ok, q.host_run};
				PRC_ERR_ADDR: d.rdata = {8'h00, q.err_info, q.err_code};
				PRC_CFG_ADDR: d.rdata = {18'h0, q.cfg.cfg_mode, q.cfg.can2_en,
					q.cfg.master_en, q.cfg.rate_sel, q.cfg.node_addr};
				default: d.rresp = PRC_RESP_SLVERR;
			endcase
		end

		// ------------------------------------------------------------
		// Host commands and error flags
		// ------------------------------------------------------------
		if (wv[PRC_CTRL_START])
		begin
			d.host_run = 1'b1;
			d.start_kind = wv[PRC_CTRL_START_KIND +: 3];
		end
		if (wv[PRC_CTRL_STOP])
			d.host_run = 1'b0;
		if (wv[PRC_CTRL_PROG_OK])
			d.prog_ok = 1'b1;
		if (wv[PRC_CTRL_COMM_OK])
			d.comm_err = 1'b0;
		if (wv[PRC_CTRL_COMM_ERR])
			d.comm_err = 1'b1;
		if (wv[PRC_CTRL_CLR_FAULT])
			d.fault = 1'b0;
		// A fault arriving in the clearing cycle is kept
		if (fault_pulse)
		begin
			d.fault = 1'b1;
			d.err_code = fault_code;
			d.err_info = fault_info;
		end

		// ------------------------------------------------------------
		// Operating state
		// ------------------------------------------------------------
		// Module reset is tested first so no fault can mask it
		if (sel_mres)
			nxt = PRC_ST_MRES;
		else if (!q.prog_ok || q.fault || fault_pulse || !q.host_run)
			nxt = PRC_ST_STOP;
		else if (sel_run)
			nxt = PRC_ST_RUN;
		else
			nxt = PRC_ST_READY;
		d.state = nxt;

		// ------------------------------------------------------------
		// LED patterns
		// ------------------------------------------------------------
		// One shared counter keeps both LEDs in step in module reset
		d.blink_cnt = q.blink_cnt + 32'd1;
		slow_ph = half_phase(q.blink_cnt, SLOW_CYC);
		fast_ph = half_phase(q.blink_cnt, FAST_CYC);
		short_ph = (q.blink_cnt % 32'(SHORT_CYC))
			< 32'(SHORT_CYC / (PRC_SHORT_ON + PRC_SHORT_OFF));
		case (q.state)
			PRC_ST_MRES:
			begin
				d.led.run_led = fast_ph;
				d.led.err_led = fast_ph;
			end
			PRC_ST_RUN: d.led.run_led = slow_ph;
			PRC_ST_READY: d.led.run_led = short_ph;
			PRC_ST_STOP: d.led.run_led = 1'b0;
			default: d.led.run_led = 1'b0;
		endcase
		if (q.state != PRC_ST_MRES)
		begin
			if (q.fault)
				d.led.err_led = 1'b1;
			else if (q.comm_err)
				d.led.err_led = slow_ph;
			else
				d.led.err_led = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.state <= PRC_ST_STOP;
		end
		else
			q <= d;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_RUN_NEEDS_BOTH: assert property (
		q.state == PRC_ST_RUN |-> $past(q.host_run) && $past(q.prog_ok)
		&& !$past(q.fault))
		else $error("run without host start or program");
	AST_READY_HOST: assert property (
		q.state == PRC_ST_READY |-> $past(q.host_run) && !$past(sel_run)
		&& !$past(sel_mres))
		else $error("ready without host run or with selector at run");
	AST_FAULT_RED: assert property (
		q.fault && q.state != PRC_ST_MRES |=> q.led.err_led)
		else $error("red not steady during fault");
	AST_LINK_KEEPS_RUN: assert property (
		q.comm_err && q.state == PRC_ST_RUN && q.host_run && q.prog_ok
		&& !q.fault && !fault_pulse && sel_run |=> q.state == PRC_ST_RUN)
		else $error("link error stopped the program");
	AST_NODE_ADDR: assert property (
		!q.cfg_done |=> q.cfg.node_addr
		== $past({addr_switch_high, addr_switch_low}))
		else $error("node address not taken from switches");
	AST_CFG_DIP: assert property (
		!q.cfg_done |=> q.cfg.master_en == $past(config_dip_bank[PRC_DIP_MASTER])
		&& q.cfg.can2_en == $past(config_dip_bank[PRC_DIP_CAN2]))
		else $error("dip bank not decoded");
	AST_LEVEL_RUN: assert property (
		q.host_run && q.prog_ok && !q.fault && !fault_pulse && sel_run
		|=> q.state == PRC_ST_RUN)
		else $error("run level not honoured");
	AST_STOP_DARK: assert property (
		q.state == PRC_ST_STOP |=> !q.led.run_led)
		else $error("green lit in stop");
	AST_MRES_BLINK: assert property (
		q.state == PRC_ST_MRES |=> q.led.run_led == q.led.err_led)
		else $error("mres leds not together");
	AST_NO_ERR_DARK: assert property (
		!q.fault && !q.comm_err && q.state != PRC_ST_MRES |=> !q.led.err_led)
		else $error("red lit without error");
	AST_FAULT_STOPS: assert property (
		fault_pulse && !sel_mres |=> q.state == PRC_ST_STOP ##1 q.led.err_led)
		else $error("fault did not stop and light red");
	AST_CODE_KEPT: assert property (
		fault_pulse |=> q.err_code == $past(fault_code))
		else $error("fault code not held");
	AST_COMM_CLR: assert property (
		wv[PRC_CTRL_COMM_OK] && !wv[PRC_CTRL_COMM_ERR] |=> !q.comm_err)
		else $error("link error not cleared");
	AST_CFG_STABLE: assert property (
		q.cfg_done |=> $stable(q.cfg))
		else $error("configuration changed in operation");
	AST_MRES_WINS: assert property (
		sel_mres |=> q.state == PRC_ST_MRES)
		else $error("module reset not taking precedence");

	// ------------------------------------------------------------
	// Register bus assertions
	// ------------------------------------------------------------
	// Bus answers must stand until the master takes them
	AST_BVALID_HOLD: assert property (
		q.bvalid && !s_axi_bready |=> q.bvalid)
		else $error("write response dropped early");
	AST_RVALID_HOLD: assert property (
		q.rvalid && !s_axi_rready |=> q.rvalid && $stable(q.rdata))
		else $error("read data dropped or changed early");
	AST_AW_REFUSE: assert property (
		q.bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	AST_AR_REFUSE: assert property (
		q.rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");

	COV_RUN: cover property (q.state == PRC_ST_READY ##[1:20]
		q.state == PRC_ST_RUN);
	COV_FAULT: cover property (q.state == PRC_ST_RUN ##1 fault_pulse);
	COV_MRES: cover property (q.state == PRC_ST_MRES);
	COV_COMM: cover property (q.comm_err ##[1:20] !q.comm_err);
	COV_READY: cover property (q.state == PRC_ST_STOP ##1
		q.state == PRC_ST_READY);

endmodule

// File: sim/prc_panel_model.sv
// Front-panel model: run selector, node-address switches, DIP bank
`timescale 1ns/10ps
module prc_panel_model
	import prc_pkg::*;
(
	// Clock and bench requests
	input wire logic sys_clk,
	input wire logic [1:0] sel_req,
	input wire logic alt_cfg,
	// Panel pins
	output logic [1:0] run_selector,
	output logic [3:0] addr_switch_high,
	output logic [3:0] addr_switch_low,
	output logic [7:0] config_dip_bank
);
	// Both node addresses stay clear of zero and the upper half
	always_ff @(posedge sys_clk)
	begin
		run_selector <= sel_req;
		{addr_switch_high, addr_switch_low} <= alt_cfg ? 8'h21 : 8'h5A;
		config_dip_bank <= alt_cfg ? 8'h00 : 8'h9D;
	end
endmodule

// File: sim/tb_plc_run_control_and_status_leds.sv
// Self-checking bench for the run-control and LED block
`timescale 1ns/10ps
module tb_plc_run_control_and_status_leds
	import prc_pkg::*;
;
	localparam int SL = 32;
	localparam int FA = 8;
	localparam int SH = 18;
	typedef struct packed
	{
		logic [1:0] sel;
		logic [31:0] cmd;
		logic [3:0] st;
	} prc_row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] sel_req = PRC_SEL_STOP;
	logic alt_cfg = 1'b0;
	logic [1:0] run_selector;
	logic [3:0] addr_switch_high, addr_switch_low;
	logic [7:0] config_dip_bank;
	logic fault_pulse = 1'b0;
	logic [7:0] fault_code = 8'h00;
	logic [15:0] fault_info = 16'h0000;
	logic run_led, err_led, prog_exec, mres_req;
	prc_cfg_t cfg_out;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	int hr, he;
	prc_row_t rows [9] = '{
		'{PRC_SEL_STOP, 32'h0000_0004, 4'h1}, '{PRC_SEL_STOP, 32'h0000_0001, 4'h2},
		'{PRC_SEL_RUN, 32'h0000_0000, 4'h4}, '{PRC_SEL_RUN, 32'h0000_0002, 4'h1},
		'{PRC_SEL_RUN, 32'h0000_0003, 4'h1}, '{PRC_SEL_RUN, 32'h0000_0101, 4'h4},
		'{PRC_SEL_MRES, 32'h0000_0000, 4'h8}, '{2'b11, 32'h0000_0000, 4'h2},
		'{PRC_SEL_RUN, 32'h0000_0201, 4'h4}};

	prc_panel_model pnl (.sys_clk, .sel_req, .alt_cfg, .run_selector,
		.addr_switch_high, .addr_switch_low, .config_dip_bank);
	prc_run_ctrl #(.SLOW_CYC(SL), .FAST_CYC(FA), .SHORT_CYC(SH)) uut (
		.sys_clk, .rst_n, .run_selector, .addr_switch_high, .addr_switch_low,
		.config_dip_bank, .fault_pulse, .fault_code, .fault_info, .run_led,
		.err_led, .prog_exec, .mres_req, .cfg_out, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	// A hung handshake ends here rather than running forever
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			error_cnt++;
			final_report();
		end
	end

	task automatic final_report();
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask

	// Bus tasks open on an edge so no strobe is raised where it fell
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Checked window lengths are whole blink periods, so phase does not matter
	task automatic leds(input int w);
		repeat (2) @(posedge sys_clk);
		hr = 0;
		he = 0;
		repeat (w)
		begin
			@(posedge sys_clk);
			hr += int'(run_led === 1'b1);
			he += int'(err_led === 1'b1);
		end
	endtask

	task automatic fault_in();
		@(posedge sys_clk);
		fault_pulse <= 1'b1;
		fault_code <= 8'hA5;
		fault_info <= 16'h1234;
		@(posedge sys_clk);
		fault_pulse <= 1'b0;
	endtask

	initial
	begin
		repeat (2) @(posedge sys_clk);
		chk("reset outs", 0, {run_led, err_led, prog_exec, mres_req});
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("cfg", 32'h0000_16AF, 32'(cfg_out));
		alt_cfg <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("cfg held", 32'h0000_16AF, 32'(cfg_out));
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("cfg alt", 32'h0000_0840, 32'(cfg_out));
		axr(PRC_CFG_ADDR);
		chk("cfg reg", 32'h0000_0021, rd);
		foreach (rows[i])
		begin
			sel_req <= rows[i].sel;
			repeat (4) @(posedge sys_clk);
			if (rows[i].cmd != 0) axw(PRC_CTRL_ADDR, rows[i].cmd);
			repeat (2) @(posedge sys_clk);
			axr(PRC_STAT_ADDR);
			chk("state", rows[i].st, rd[7:4]);
			chk("exec", rows[i].st == 4'h4, prog_exec);
			chk("mres", rows[i].st == 4'h8, mres_req);
		end
		axr(PRC_CTRL_ADDR);
		chk("start kind", 2, rd[10:8]);
		leds(4 * SL);
		chk("green run", 2 * SL, hr);
		chk("red dark", 0, he);
		axw(PRC_CTRL_ADDR, 32'h0000_0008);
		leds(4 * SL);
		chk("red link", 2 * SL, he);
		chk("exec link", 1, prog_exec);
		axw(PRC_CTRL_ADDR, 32'h0000_0010);
		leds(4 * SL);
		chk("red cleared", 0, he);
		axw(PRC_CTRL_ADDR, 32'h0000_0008);
		fault_in();
		leds(4 * SL);
		chk("red fault", 4 * SL, he);
		chk("green fault", 0, hr);
		chk("exec fault", 0, prog_exec);
		axr(PRC_ERR_ADDR);
		chk("err code", 32'h0012_34A5, rd);
		sel_req <= PRC_SEL_MRES;
		leds(6 + 4 * FA);
		leds(4 * FA);
		chk("green mres", 2 * FA, hr);
		chk("red mres", 2 * FA, he);
		sel_req <= PRC_SEL_STOP;
		axw(PRC_CTRL_ADDR, 32'h0000_0031);
		leds(2 * SH);
		chk("green short", 4, hr);
		axr(8'h10);
		chk("unmapped", PRC_RESP_SLVERR, rsp);
		axw(PRC_STAT_ADDR, 32'h0000_0000);
		chk("ro write", PRC_RESP_SLVERR, rsp);
		final_report();
	end
endmodule
